// ===== core/capture_regs.vh
`ifndef CAPTURE_REGS_VH
`define CAPTURE_REGS_VH

`define ADDR_W 6
`define REG_CTRL 6'h00
`define REG_CLKSEL 6'h04
`define REG_RECLEN 6'h08
`define REG_STATUS 6'h0c
`define REG_COUNT 6'h10
`define REG_IRQ_STAT 6'h14
`define REG_IRQ_MASK 6'h18
`define REG_SAMPINT 6'h1c
`define REG_TDELAY 6'h20
`define REG_DELAYCNT 6'h24
`define REG_MEMIDX 6'h28
`define REG_MEMDATA 6'h2c

`define CTRL_ARM 0
`define CTRL_HALT 1
`define CTRL_COMBINE 2

`define CLKSEL_W 3
`define CLKSEL_START_STOP 3'h4
`define CLKSEL_RESET 3'h0

`define ST_READY 0
`define ST_RUNNING 1
`define ST_FLUSHING 2
`define ST_DONE 3
`define ST_LEN_REACHED 4
`define ST_COMBINE 5

`define IRQ_W 4
`define IRQ_DONE 0
`define IRQ_LEN 1
`define IRQ_GAP 2
`define IRQ_OVERFLOW 3

`define CLK_PERIOD_NS 100
`define GAP_NS 100
`define GAP_CYC ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLUSH_EDGES 320

`endif

// ===== core/edge_sync.v
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser with a third stage for edge detection
module edge_sync (
   input wire mclk,
   input wire nrst,
   input wire pin,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta;
   reg sync;
   reg last;

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end

   assign level = sync;
   assign rise = sync & ~last;
   assign fall = ~sync & last;
endmodule
`default_nettype wire

// ===== core/capture_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "capture_regs.vh"
module capture_ctrl #(
   parameter SAMPLE_W = 8,
   parameter CONV_PER_EDGE = 1,
   parameter DEPTH = 64,
   parameter IDX_W = 6,
   parameter LEN_W = 16,
   parameter FLUSH_EDGES = `FLUSH_EDGES,
   parameter GAP_CYC = `GAP_CYC
) (
   input wire mclk,
   input wire nrst,
   input wire [`ADDR_W-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire ext_clk,
   input wire [SAMPLE_W*CONV_PER_EDGE-1:0] sample_in,
   input wire trig_in,
   output wire irq
);
   // Several converter lanes per edge share one memory word
   localparam WORD_W = SAMPLE_W * CONV_PER_EDGE;

   localparam S_IDLE = 3'd0;
   localparam S_READY = 3'd1;
   localparam S_RUN = 3'd2;
   localparam S_FLUSH = 3'd3;
   localparam S_DONE = 3'd4;

   // Threshold comparator output: one sample per rising crossing
   // The pin is asynchronous, so nothing decodes it before two flops
   wire clk_level;
   wire clk_rise;
   wire clk_fall;
   edge_sync u_clk_sync (
      .mclk(mclk),
      .nrst(nrst),
      .pin(ext_clk),
      .level(clk_level),
      .rise(clk_rise),
      .fall(clk_fall)
   );

   // Data delayed to line up with the synchronised clock edge
   reg [WORD_W-1:0] data_meta;
   reg [WORD_W-1:0] data_sync;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [`CLKSEL_W-1:0] clock_source_select;
   reg [LEN_W-1:0] record_length_config;
   reg combine_req;
   reg [31:0] sample_interval_setting;
   reg [31:0] trigger_delay_time;
   reg [31:0] delay_sample_count;
   reg [LEN_W-1:0] sample_count;
   reg [15:0] flush_count;
   reg [IDX_W-1:0] mem_idx;
   reg [`IRQ_W-1:0] irq_stat;
   reg [`IRQ_W-1:0] irq_mask;
   reg len_reached;
   reg gap_pending;
   reg [7:0] idle_cycles;
   reg [WORD_W-1:0] mem [0:DEPTH-1];

   wire start_stop = (clock_source_select == `CLKSEL_START_STOP);
   wire wr_ctrl = wr && (addr == `REG_CTRL);
   wire arm_cmd = wr_ctrl && wdata[`CTRL_ARM] && start_stop;
   wire halt_cmd = wr_ctrl && wdata[`CTRL_HALT];
   wire capturing = (state == S_RUN) || (state == S_FLUSH);
   // Edges in READY begin the record; triggers play no part at all
   wire take = clk_rise && (capturing || state == S_READY);
   wire room = (sample_count < DEPTH[LEN_W-1:0]);
   wire store = take && room;
   wire hit_len = take && (sample_count + 1'b1 >= record_length_config);
   wire flush_end = (state == S_FLUSH) && clk_rise
                    && (flush_count + 1'b1 >= FLUSH_EDGES[15:0]);
   // Gap is measured in system clocks, so it resolves no finer than one period
   wire gap_long = (idle_cycles > GAP_CYC[7:0]);

   reg [`IRQ_W-1:0] irq_event;

   function [31:0] pad_word;
      input [WORD_W-1:0] w;
      begin
         pad_word = 32'h0000_0000;
         pad_word[WORD_W-1:0] = w;
      end
   endfunction

   function [31:0] pad_len;
      input [LEN_W-1:0] v;
      begin
         pad_len = 32'h0000_0000;
         pad_len[LEN_W-1:0] = v;
      end
   endfunction

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         data_meta <= {WORD_W{1'b0}};
         data_sync <= {WORD_W{1'b0}};
      end else begin
         data_meta <= sample_in;
         data_sync <= data_meta;
      end
   end

   always @* begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (arm_cmd) begin
               next_state = S_READY;
            end
         end
         S_READY: begin
            if (halt_cmd) begin
               next_state = S_DONE;
            end else if (take) begin
               next_state = hit_len ? S_FLUSH : S_RUN;
            end
         end
         S_RUN: begin
            if (halt_cmd) begin
               next_state = S_DONE;
            end else if (hit_len) begin
               next_state = S_FLUSH;
            end
         end
         S_FLUSH: begin
            if (halt_cmd || flush_end) begin
               next_state = S_DONE;
            end
         end
         S_DONE: begin
            if (arm_cmd) begin
               next_state = S_READY;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      // Leaving start/stop mode returns to idle; the mode cannot be left while a record is in progress
      if (!start_stop) begin
         next_state = S_IDLE;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Counter restarts on arm; it keeps running past the length so surplus edges are seen
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sample_count <= {LEN_W{1'b0}};
         flush_count <= 16'h0000;
         len_reached <= 1'b0;
      end else if (arm_cmd) begin
         sample_count <= {LEN_W{1'b0}};
         flush_count <= 16'h0000;
         len_reached <= 1'b0;
      end else if (take && next_state != S_DONE) begin
         if (room) begin
            sample_count <= sample_count + 1'b1;
         end
         if (state == S_FLUSH) begin
            flush_count <= flush_count + 1'b1;
         end
         if (hit_len) begin
            len_reached <= 1'b1;
         end
      end
   end

   // Linear fill: the index is the sample count, so surplus words land after the record
   always @(posedge mclk) begin
      if (store && next_state != S_DONE) begin
         mem[sample_count[IDX_W-1:0]] <= data_sync;
      end
   end

   // Idle time of the link clock; a long pause marks the next sample suspect
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         idle_cycles <= 8'h00;
         gap_pending <= 1'b0;
      end else begin
         if (clk_rise || clk_fall) begin
            idle_cycles <= 8'h00;
         end else if (idle_cycles != 8'hff) begin
            idle_cycles <= idle_cycles + 8'h01;
         end
         if (arm_cmd || take) begin
            gap_pending <= 1'b0;
         end else if (gap_long && capturing) begin
            gap_pending <= 1'b1;
         end
      end
   end

   always @* begin
      irq_event = {`IRQ_W{1'b0}};
      irq_event[`IRQ_DONE] = (state != S_DONE) && (next_state == S_DONE);
      irq_event[`IRQ_LEN] = hit_len && (state == S_RUN || state == S_READY);
      irq_event[`IRQ_GAP] = take && gap_pending;
      // Surplus beyond memory is expected while flushing, so only RUN flags overflow
      irq_event[`IRQ_OVERFLOW] = take && !room && (state == S_RUN);
   end

   // Set wins over a write-one clear in the same cycle
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_stat <= {`IRQ_W{1'b0}};
         irq_mask <= {`IRQ_W{1'b0}};
      end else begin
         if (wr && addr == `REG_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wdata[`IRQ_W-1:0]) | irq_event;
         end else begin
            irq_stat <= irq_stat | irq_event;
         end
         if (wr && addr == `REG_IRQ_MASK) begin
            irq_mask <= wdata[`IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // Configuration writes; capture settings lock while a record is in progress
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         clock_source_select <= `CLKSEL_RESET;
         record_length_config <= {LEN_W{1'b0}};
         combine_req <= 1'b0;
         sample_interval_setting <= 32'h0000_0000;
         trigger_delay_time <= 32'h0000_0000;
         delay_sample_count <= 32'h0000_0000;
         mem_idx <= {IDX_W{1'b0}};
      end else if (wr) begin
         case (addr)
            `REG_CTRL: begin
               // Interleaving cannot be enabled in start/stop mode
               combine_req <= wdata[`CTRL_COMBINE] && !start_stop;
            end
            `REG_CLKSEL: begin
               if (!capturing) begin
                  clock_source_select <= wdata[`CLKSEL_W-1:0];
                  if (wdata[`CLKSEL_W-1:0] == `CLKSEL_START_STOP) begin
                     combine_req <= 1'b0;
                  end
               end
            end
            `REG_RECLEN: begin
               if (!capturing) begin
                  record_length_config <= wdata[LEN_W-1:0];
               end
            end
            // Held for other clock modes only; only the register read-back here uses them
            `REG_SAMPINT: begin
               sample_interval_setting <= wdata;
            end
            `REG_TDELAY: begin
               trigger_delay_time <= wdata;
            end
            `REG_DELAYCNT: begin
               delay_sample_count <= wdata;
            end
            `REG_MEMIDX: begin
               mem_idx <= wdata[IDX_W-1:0];
            end
            default: begin
               mem_idx <= mem_idx;
            end
         endcase
      end
   end

   // Read data stands for exactly one cycle after the strobe
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            `REG_CTRL: begin
               rdata <= {29'h0, combine_req, 2'b00};
            end
            `REG_CLKSEL: begin
               rdata <= {29'h0, clock_source_select};
            end
            `REG_RECLEN: begin
               rdata <= pad_len(record_length_config);
            end
            `REG_STATUS: begin
               rdata <= {26'h0, combine_req, len_reached, state == S_DONE, state == S_FLUSH,
                         state == S_RUN, state == S_READY};
            end
            `REG_COUNT: begin
               rdata <= pad_len(sample_count);
            end
            `REG_IRQ_STAT: begin
               rdata <= {28'h0, irq_stat};
            end
            `REG_IRQ_MASK: begin
               rdata <= {28'h0, irq_mask};
            end
            `REG_SAMPINT: begin
               rdata <= sample_interval_setting;
            end
            `REG_TDELAY: begin
               rdata <= trigger_delay_time;
            end
            `REG_DELAYCNT: begin
               rdata <= delay_sample_count;
            end
            `REG_MEMIDX: begin
               rdata <= {{(32-IDX_W){1'b0}}, mem_idx};
            end
            `REG_MEMDATA: begin
               rdata <= pad_word(mem[mem_idx]);
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // The trigger pin has no effect in this mode
   // Only a sink for otherwise unread inputs; it drives nothing
   wire unused_ok = trig_in & clk_level;
endmodule
`default_nettype wire

// ===== tb/capture_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "capture_regs.vh"
module capture_checker #(
   parameter DEPTH = 64
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic irq
);
   logic [3:0] mask;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mask <= 4'h0;
      end else if (wr && addr == `REG_IRQ_MASK) begin
         mask <= wdata[3:0];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property (rd && (addr > 6'h2c || addr[1:0] != 2'h0) |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_state_onehot: assert property (rd && addr == `REG_STATUS |=> $onehot0(rdata[3:0]))
      else $error("status state bits not exclusive");
   a_combine_excl: assert property (rd && addr == `REG_STATUS |=> !(rdata[5] && |rdata[2:0]))
      else $error("combine while capture mode active");
   a_count_bound: assert property (rd && addr == `REG_COUNT |=> rdata <= DEPTH)
      else $error("count beyond memory depth");
   a_clksel_width: assert property (rd && addr == `REG_CLKSEL |=> rdata[31:3] == 29'h0)
      else $error("source select upper bits set");
   a_mask_off: assert property (wr && addr == `REG_IRQ_MASK && wdata[3:0] == 4'h0 |=> !irq)
      else $error("irq with all sources masked");
   a_irq_masked: assert property (irq |-> mask != 4'h0)
      else $error("irq without enabled source");
   cover property (rd && addr == `REG_STATUS ##1 rdata[3]);
   cover property ($rose(irq));
   cover property (wr && addr == `REG_CTRL && wdata[1]);
endmodule
bind capture_ctrl capture_checker #(.DEPTH(DEPTH)) i_capture_checker (
   .mclk(mclk),
   .nrst(nrst),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata(rdata),
   .irq(irq)
);
`default_nettype wire

// ===== tb/ext_burst_src.sv
`timescale 1ns/100ps
`default_nettype none
module ext_burst_src (
   output var logic ext_clk,
   output var logic [7:0] sample_in
);
   logic [7:0] seq;
   initial begin
      ext_clk = 1'b0;
      seq = 8'h10;
      sample_in = 8'hef;
   end
   // Period scaled to 800 ns so the slow system clock sees every phase
   task automatic burst(input int n);
      // Start off the system clock edge so the pin never changes as it is sampled
      #25;
      // Back-to-back pulses also stand in for a continuous clock
      repeat (n) begin
         sample_in = seq;
         #400 ext_clk = 1'b1;
         #400 ext_clk = 1'b0;
         seq = seq + 8'h01;
      end
      // Idle clock stays low; data no longer holds the last sample
      sample_in = ~sample_in;
   endtask
endmodule
`default_nettype wire

// ===== tb/capture_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "capture_regs.vh"
module capture_ctrl_tb;
   logic mclk, nrst, wr, rd, trig_in;
   logic [`ADDR_W-1:0] addr;
   logic [31:0] wdata;
   wire [31:0] rdata;
   wire ext_clk, irq;
   wire [7:0] sample_in;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   capture_ctrl #(.FLUSH_EDGES(4), .GAP_CYC(20)) i_capture_ctrl (
      .mclk(mclk),
      .nrst(nrst),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .ext_clk(ext_clk),
      .sample_in(sample_in),
      .trig_in(trig_in),
      .irq(irq)
   );
   ext_burst_src i_ext_burst_src (
      .ext_clk(ext_clk),
      .sample_in(sample_in)
   );
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Trigger pin keeps toggling; the capture must not care
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         trig_in <= 1'b0;
      end else begin
         trig_in <= ~trig_in;
      end
   end
   task tally_and_finish;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc > 5000) begin
         error_cnt = error_cnt + 1;
         tally_and_finish();
      end
   end
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked = checked + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr_reg(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rd_chk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 check(nm, exp, rdata & m);
   endtask
   task settle;
      repeat (5) @(posedge mclk);
   endtask
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 6'h00;
      wdata = 32'h0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      rd_chk("clksel", `REG_CLKSEL, 32'hffffffff, 32'h0);
      rd_chk("unmapped", 6'h30, 32'hffffffff, 32'h0);
      wr_reg(`REG_CTRL, 32'h1);
      rd_chk("status", `REG_STATUS, 32'h3f, 32'h0);
      wr_reg(`REG_CLKSEL, 32'h4);
      rd_chk("clksel", `REG_CLKSEL, 32'hffffffff, 32'h4);
      wr_reg(`REG_CTRL, 32'h4);
      rd_chk("combine", `REG_STATUS, 32'h20, 32'h0);
      wr_reg(`REG_SAMPINT, 32'h5);
      wr_reg(`REG_TDELAY, 32'h5);
      wr_reg(`REG_DELAYCNT, 32'h5);
      wr_reg(`REG_RECLEN, 32'h3);
      wr_reg(`REG_IRQ_MASK, 32'h3);
      wr_reg(`REG_CTRL, 32'h1);
      rd_chk("status", `REG_STATUS, 32'h3f, 32'h1);
      repeat (10) @(posedge mclk);
      rd_chk("count", `REG_COUNT, 32'hffff, 32'h0);
      i_ext_burst_src.burst(2);
      repeat (30) @(posedge mclk);
      i_ext_burst_src.burst(1);
      settle();
      rd_chk("count", `REG_COUNT, 32'hffff, 32'h3);
      rd_chk("status", `REG_STATUS, 32'h1f, 32'h14);
      check("irq", 32'h1, {31'h0, irq});
      rd_chk("irqstat", `REG_IRQ_STAT, 32'h6, 32'h6);
      i_ext_burst_src.burst(4);
      settle();
      rd_chk("status", `REG_STATUS, 32'hf, 32'h8);
      for (int i = 0; i < 6; i++) begin
         wr_reg(`REG_MEMIDX, i);
         rd_chk("mem", `REG_MEMDATA, 32'hff, 32'h10 + i);
      end
      wr_reg(`REG_IRQ_STAT, 32'hf);
      #1 check("irq", 32'h0, {31'h0, irq});
      wr_reg(`REG_RECLEN, 32'h2);
      wr_reg(`REG_CTRL, 32'h1);
      i_ext_burst_src.burst(2);
      settle();
      wr_reg(`REG_CTRL, 32'h2);
      rd_chk("status", `REG_STATUS, 32'hf, 32'h8);
      rd_chk("count", `REG_COUNT, 32'hffff, 32'h2);
      wr_reg(`REG_MEMIDX, 32'h0);
      rd_chk("mem", `REG_MEMDATA, 32'hff, 32'h17);
      check("irq", 32'h1, {31'h0, irq});
      wr_reg(`REG_IRQ_MASK, 32'h0);
      #1 check("irq", 32'h0, {31'h0, irq});
      repeat (2) @(posedge mclk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
